// ---- hw/mxe_pkg.sv ----
// package: constants, operation codes and carriers for the execution core
package mxe_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [10:0] PC_RESET = 11'h000;
  localparam int unsigned PC_W = 11;
  localparam int unsigned STACK_DEPTH = 8;

  // ************************************************************
  // operations
  // ************************************************************
  typedef enum logic [4:0] {
    MXE_OP_NOP = 5'h00,
    MXE_OP_LD_ACC_MEM = 5'h01,
    MXE_OP_ST_ACC_MEM = 5'h02,
    MXE_OP_LD_ACC_IMM = 5'h03,
    MXE_OP_ADD = 5'h04,
    MXE_OP_SUB = 5'h05,
    MXE_OP_AND = 5'h06,
    MXE_OP_OR = 5'h07,
    MXE_OP_XOR = 5'h08,
    MXE_OP_INVERT = 5'h09,
    MXE_OP_INC = 5'h0a,
    MXE_OP_DECR = 5'h0b,
    MXE_OP_ROR = 5'h0c,
    MXE_OP_ROL = 5'h0d,
    MXE_OP_RORC = 5'h0e,
    MXE_OP_ROLC = 5'h0f,
    MXE_OP_BSET = 5'h10,
    MXE_OP_BCLR = 5'h11,
    MXE_OP_SKZ = 5'h12,
    MXE_OP_SKBZ = 5'h13,
    MXE_OP_SKBNZ = 5'h14,
    MXE_OP_JUMP = 5'h15,
    MXE_OP_CALL = 5'h16,
    MXE_OP_RETURN = 5'h17,
    MXE_OP_INT_RETURN = 5'h18,
    MXE_OP_TABRD = 5'h19,
    MXE_OP_HALT = 5'h1a,
    MXE_OP_WDTCLR = 5'h1b
  } mxe_op_e;

  // instruction word layout: op, to-memory flag, immediate flag, bit index, operand
  typedef struct packed {
    mxe_op_e op;
    logic to_mem;
    logic with_imm;
    logic [2:0] bit_idx;
    logic [10:0] operand;
  } mxe_instr_s;

  localparam int unsigned INSTR_W = $bits(mxe_instr_s);

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mxe_dmem_s;
endpackage : mxe_pkg

// ---- hw/mxe_core.sv ----
// module: instruction sequencing, timing and execution for the core
// ************************************************************
// ************************************************************
module mxe_core
  import mxe_pkg::*;
#(
  parameter int unsigned DEPTH = STACK_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rstn,
  output logic [PC_W-1:0] pmem_addr,
  input wire logic [INSTR_W-1:0] pmem_rdata,
  output logic [7:0] dmem_addr,
  input wire logic [7:0] dmem_rdata,
  output logic dmem_we,
  output logic [7:0] dmem_wdata,
  output logic [7:0] tbl_high,
  output logic [7:0] acc,
  output logic carry_flag,
  output logic zero_flag,
  output logic global_interrupt_enable,
  output logic power_down,
  output logic wdt_clear,
  output logic cycle_end
);

  // ************************************************************
  // phase counter and fetch/flush state
  // ************************************************************
  typedef enum logic [1:0] {
    MXE_EXEC = 2'b00,
    MXE_FLUSH = 2'b01,
    MXE_TABLE = 2'b10
  } mxe_state_e;

  logic [1:0] phase_q;
  mxe_state_e state_q;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] tbl_addr_q, fa_q;
  logic [7:0] acc_q;
  logic c_q, z_q, gie_q, pd_q, wdt_q, end_q, we_q;
  logic [7:0] daddr_q, wdata_q, tblh_q;
  logic [PC_W-1:0] stack_q [DEPTH];
  logic [$clog2(DEPTH)-1:0] sp_q;
  mxe_instr_s ins;
  logic [7:0] mval;
  logic [8:0] sum;
  logic [7:0] res;
  logic res_wr, res_mem, skip, pc_low_wr, flow;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  logic last;

  assign ins = mxe_instr_s'(pmem_rdata);
  assign mval = ins.with_imm ? ins.operand[7:0] : dmem_rdata;
  assign last = (phase_q == PHASE_LAST);

  // four clocks per instruction cycle
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      phase_q <= PHASE_RESET;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // ************************************************************
  // execute datapath
  // ************************************************************
  always_comb begin
    sum = 9'h000;
    res = acc_q;
    res_wr = 1'b0;
    skip = 1'b0;
    unique case (ins.op)
      MXE_OP_LD_ACC_MEM, MXE_OP_LD_ACC_IMM: begin
        res = mval;
        res_wr = 1'b1;
      end
      MXE_OP_ST_ACC_MEM: begin
        res = acc_q;
        res_wr = 1'b1;
      end
      MXE_OP_ADD: begin
        sum = {1'b0, acc_q} + {1'b0, mval};
        res = sum[7:0];
        res_wr = 1'b1;
      end
      MXE_OP_SUB: begin
        sum = {1'b0, acc_q} - {1'b0, mval};
        res = sum[7:0];
        res_wr = 1'b1;
      end
      MXE_OP_AND: begin
        res = acc_q & mval;
        res_wr = 1'b1;
      end
      MXE_OP_OR: begin
        res = acc_q | mval;
        res_wr = 1'b1;
      end
      MXE_OP_XOR: begin
        res = acc_q ^ mval;
        res_wr = 1'b1;
      end
      MXE_OP_INVERT: begin
        res = ~mval;
        res_wr = 1'b1;
      end
      MXE_OP_INC: begin
        res = mval + 8'h01;
        res_wr = 1'b1;
      end
      MXE_OP_DECR: begin
        res = mval - 8'h01;
        res_wr = 1'b1;
      end
      MXE_OP_ROR: begin
        res = {mval[0], mval[7:1]};
        res_wr = 1'b1;
      end
      MXE_OP_ROL: begin
        res = {mval[6:0], mval[7]};
        res_wr = 1'b1;
      end
      MXE_OP_RORC: begin
        res = {c_q, mval[7:1]};
        res_wr = 1'b1;
      end
      MXE_OP_ROLC: begin
        res = {mval[6:0], c_q};
        res_wr = 1'b1;
      end
      MXE_OP_BSET: begin
        res = mval | (8'h01 << ins.bit_idx);
        res_wr = 1'b1;
      end
      MXE_OP_BCLR: begin
        res = mval & ~(8'h01 << ins.bit_idx);
        res_wr = 1'b1;
      end
      MXE_OP_SKZ: skip = (dmem_rdata == 8'h00);
      MXE_OP_SKBZ: skip = !dmem_rdata[ins.bit_idx];
      MXE_OP_SKBNZ: skip = dmem_rdata[ins.bit_idx];
      default: begin
        res = acc_q;
      end
    endcase
  end

  // bit ops and store always target memory; the rest honour to_mem
  assign res_mem = res_wr && (ins.to_mem || ins.op == MXE_OP_ST_ACC_MEM ||
                   ins.op == MXE_OP_BSET || ins.op == MXE_OP_BCLR);
  assign pc_low_wr = res_mem && (ins.operand[7:0] == 8'h00);
  assign flow = (ins.op == MXE_OP_JUMP) || (ins.op == MXE_OP_CALL) ||
                (ins.op == MXE_OP_RETURN) || (ins.op == MXE_OP_INT_RETURN) ||
                skip || pc_low_wr;

  // ************************************************************
  // sequencing: program counter, stack, state
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pc_q <= PC_RESET;
      sp_q <= '0;
      state_q <= MXE_EXEC;
      tbl_addr_q <= PC_RESET;
      gie_q <= 1'b0;
    end else if (last && !pd_q) begin
      unique case (state_q)
        MXE_EXEC: begin
          state_q <= flow ? MXE_FLUSH : MXE_EXEC;
          pc_q <= pc_q + 11'h001;
          if (ins.op == MXE_OP_TABRD) begin
            tbl_addr_q <= {3'h0, acc_q};
            state_q <= MXE_TABLE;
          end
          if (ins.op == MXE_OP_JUMP) begin
            pc_q <= ins.operand;
          end
          if (ins.op == MXE_OP_CALL) begin
            stack_q[sp_q] <= pc_q + 11'h001;
            sp_q <= sp_q + 1'b1;
            pc_q <= ins.operand;
          end
          if (ins.op == MXE_OP_RETURN || ins.op == MXE_OP_INT_RETURN) begin
            pc_q <= stack_q[sp_q - 1'b1];
            sp_q <= sp_q - 1'b1;
          end
          if (ins.op == MXE_OP_INT_RETURN) begin
            gie_q <= 1'b1;
          end
          if (skip) begin
            pc_q <= pc_q + 11'h002;
          end
          if (pc_low_wr) begin
            pc_q <= {pc_q[PC_W-1:8], res};
          end
        end
        MXE_FLUSH, MXE_TABLE: state_q <= MXE_EXEC;
        default: state_q <= MXE_EXEC;
      endcase
    end
  end

  // ************************************************************
  // accumulator and flags
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      acc_q <= ACC_RESET;
      c_q <= 1'b0;
      z_q <= 1'b0;
    end else if (last && state_q == MXE_EXEC && !pd_q) begin
      if (res_wr && !res_mem) begin
        acc_q <= res;
      end
      if (ins.op == MXE_OP_ADD) begin
        c_q <= sum[8];
      end
      if (ins.op == MXE_OP_SUB) begin
        c_q <= !sum[8];
      end
      if (ins.op == MXE_OP_RORC) begin
        c_q <= mval[0];
      end
      if (ins.op == MXE_OP_ROLC) begin
        c_q <= mval[7];
      end
      if (ins.op inside {MXE_OP_AND, MXE_OP_OR, MXE_OP_XOR, MXE_OP_INVERT,
          MXE_OP_ADD, MXE_OP_SUB, MXE_OP_INC, MXE_OP_DECR}) begin
        z_q <= (res == 8'h00);
      end
    end
  end

  // ************************************************************
  // memory ports, table, power-down and watchdog
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      we_q <= 1'b0;
      daddr_q <= 8'h00;
      wdata_q <= 8'h00;
      tblh_q <= 8'h00;
      pd_q <= 1'b0;
      wdt_q <= 1'b0;
      end_q <= 1'b0;
      fa_q <= PC_RESET;
    end else begin
      fa_q <= (state_q == MXE_TABLE) ? tbl_addr_q : pc_q;
      daddr_q <= (state_q == MXE_TABLE) ? daddr_q :
                 ins.operand[7:0];
      end_q <= (phase_q == 2'h2);
      we_q <= (phase_q == 2'h2) && state_q == MXE_EXEC && res_mem &&
              !pd_q;
      wdata_q <= res;
      wdt_q <= (phase_q == 2'h2) && state_q == MXE_EXEC &&
               ins.op == MXE_OP_WDTCLR;
      if (last && state_q == MXE_EXEC && ins.op == MXE_OP_HALT) begin
        pd_q <= 1'b1;
      end
      if (last && state_q == MXE_TABLE) begin
        tblh_q <= pmem_rdata[15:8];
        we_q <= 1'b1;
        wdata_q <= pmem_rdata[7:0];
      end
    end
  end

  // registered fetch address: stale in phase 0, used from phase 1
  assign pmem_addr = fa_q;
  assign dmem_addr = daddr_q;
  assign dmem_we = we_q;
  assign dmem_wdata = wdata_q;
  assign tbl_high = tblh_q;
  assign acc = acc_q;
  assign carry_flag = c_q;
  assign zero_flag = z_q;
  assign global_interrupt_enable = gie_q;
  assign power_down = pd_q;
  assign wdt_clear = wdt_q;
  assign cycle_end = end_q;

  // ************************************************************
  // checks
  // ************************************************************
  sequence q_flush_to_exec;
    state_q == MXE_FLUSH ##4 state_q == MXE_EXEC;
  endsequence
  a_phase_wraps: assert property (phase_q == PHASE_LAST |=>
    phase_q == 2'h0)
    else $error("phase did not wrap after four clocks");
  a_jump_flush: assert property (last && state_q == MXE_EXEC &&
    !pd_q && ins.op == MXE_OP_JUMP
    |=> state_q == MXE_FLUSH && pc_q == $past(ins.operand))
    else $error("jump did not load target and flush");
  a_flush_len: assert property (state_q == MXE_FLUSH && last |=>
    state_q == MXE_EXEC)
    else $error("flush lasted more than one cycle");
  a_int_exit_gie: assert property (last && state_q == MXE_EXEC &&
    !pd_q && ins.op == MXE_OP_INT_RETURN
    |=> gie_q)
    else $error("interrupt return left enable low");
  a_halt_holds: assert property (pd_q |=> pd_q && $stable(pc_q))
    else $error("power down left or pc moved");
  a_add_carry: assert property (last && state_q == MXE_EXEC &&
    !pd_q && ins.op == MXE_OP_ADD |=> c_q == $past(sum[8]))
    else $error("add carry wrong");
  a_skip_pc: assert property (last && state_q == MXE_EXEC && !pd_q &&
    skip && ins.op != MXE_OP_TABRD
    |=> pc_q == $past(pc_q) + 11'h002 ##0 q_flush_to_exec)
    else $error("skip did not advance by two");
  a_we_pulse: assert property (we_q |=> !we_q)
    else $error("memory write longer than one clock");
endmodule // mxe_core

// ---- bench/mxe_mem_model.sv ----
// partner model: program memory and data memory of the core
module mxe_mem_model
  import mxe_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [PC_W-1:0] pmem_addr,
  output logic [INSTR_W-1:0] pmem_rdata,
  input wire logic [7:0] dmem_addr,
  output logic [7:0] dmem_rdata,
  input wire logic dmem_we,
  input wire logic [7:0] dmem_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // storage
  // ************************************************************
  logic [INSTR_W-1:0] pmem [0:2047];
  logic [7:0] dmem [0:255];
  // reads are combinational: the core samples them in the same cycle
  assign pmem_rdata = pmem[pmem_addr];
  assign dmem_rdata = dmem[dmem_addr];
  // plain always: the bench also preloads this array
  always @(posedge sys_clk) begin
    if (dmem_we) begin
      dmem[dmem_addr] <= dmem_wdata;
    end
  end
endmodule // mxe_mem_model

// ---- bench/mxe_core_tb.sv ----
// testbench: instruction timing and execution of the core
module mxe_core_tb
  import mxe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // harness
  // ************************************************************
  logic sys_clk, rstn, dmem_we, carry_flag, zero_flag;
  logic global_interrupt_enable, power_down, wdt_clear, cycle_end;
  logic [PC_W-1:0] pmem_addr;
  logic [INSTR_W-1:0] pmem_rdata;
  logic [7:0] dmem_addr, dmem_rdata, dmem_wdata, tbl_high, acc;
  int failures = 0;
  int checks = 0;

  mxe_core mxe_core_inst (.sys_clk(sys_clk), .rstn(rstn),
    .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
    .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata), .dmem_we(dmem_we),
    .dmem_wdata(dmem_wdata), .tbl_high(tbl_high), .acc(acc),
    .carry_flag(carry_flag), .zero_flag(zero_flag),
    .global_interrupt_enable(global_interrupt_enable),
    .power_down(power_down), .wdt_clear(wdt_clear),
    .cycle_end(cycle_end));
  mxe_mem_model mxe_mem_model_inst (.sys_clk(sys_clk),
    .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
    .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata), .dmem_we(dmem_we),
    .dmem_wdata(dmem_wdata));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // f is {to_mem, with_imm}
  task automatic pm(input int a, input mxe_op_e op, input logic [1:0] f,
                    input logic [2:0] b, input logic [10:0] v);
    mxe_mem_model_inst.pmem[a] = {op, f, b, v};
  endtask

  task automatic boot;
    @(posedge sys_clk);
    rstn <= 1'b0;
    // clear only once the core's last write strobe has drained
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 2048; i++) begin
      mxe_mem_model_inst.pmem[i] = '0;
    end
    for (int i = 0; i < 256; i++) begin
      mxe_mem_model_inst.dmem[i] = 8'h00;
    end
  endtask

  // reset spans 12 clocks with boot's three; program is loaded meanwhile
  task automatic rel;
    repeat (9) @(posedge sys_clk);
    rstn <= 1'b1;
  endtask

  // four clocks per instruction are fixed, so fixed waits are exact
  task automatic go(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic s_jump;
    boot();
    pm(0, MXE_OP_LD_ACC_IMM, 2'h1, 3'h0, 11'h011);
    pm(1, MXE_OP_JUMP, 2'h0, 3'h0, 11'h004);
    pm(2, MXE_OP_LD_ACC_IMM, 2'h1, 3'h0, 11'h0ee);
    pm(4, MXE_OP_LD_ACC_IMM, 2'h1, 3'h0, 11'h022);
    rel();
    go(4);
    chk(acc, 8'h11);
    go(11);
    chk(acc, 8'h11);
    go(1);
    chk(acc, 8'h22);
  endtask

  task automatic s_call(input mxe_op_e op, input logic [7:0] v,
                        input logic g);
    boot();
    pm(0, MXE_OP_CALL, 2'h0, 3'h0, 11'h005);
    pm(1, MXE_OP_LD_ACC_IMM, 2'h1, 3'h0, {3'h0, v});
    pm(5, op, 2'h0, 3'h0, 11'h000);
    rel();
    go(19);
    chk(acc, 8'h00);
    go(1);
    chk(acc, v);
    chk({7'h00, global_interrupt_enable}, {7'h00, g});
  endtask

  task automatic s_alu;
    boot();
    pm(0, MXE_OP_LD_ACC_IMM, 2'h1, 3'h0, 11'h0f0);
    pm(1, MXE_OP_ADD, 2'h1, 3'h0, 11'h020);
    pm(2, MXE_OP_SUB, 2'h1, 3'h0, 11'h020);
    pm(3, MXE_OP_AND, 2'h1, 3'h0, 11'h00f);
    pm(4, MXE_OP_OR, 2'h1, 3'h0, 11'h001);
    pm(5, MXE_OP_XOR, 2'h1, 3'h0, 11'h001);
    rel();
    go(8);
    chk({acc[6:0], carry_flag}, 8'h21);
    go(4);
    chk({acc[6:0], carry_flag}, 8'he0);
    go(4);
    chk({acc[6:0], zero_flag}, 8'h01);
    go(4);
    chk({acc[6:0], zero_flag}, 8'h02);
    go(4);
    chk({acc[6:0], zero_flag}, 8'h01);
  endtask

  task automatic s_mem;
    boot();
    mxe_mem_model_inst.dmem[8'h20] = 8'h81;
    pm(0, MXE_OP_LD_ACC_MEM, 2'h0, 3'h0, 11'h020);
    pm(1, MXE_OP_ROLC, 2'h0, 3'h0, 11'h020);
    pm(2, MXE_OP_BSET, 2'h2, 3'h6, 11'h020);
    pm(3, MXE_OP_INC, 2'h2, 3'h0, 11'h020);
    pm(4, MXE_OP_DECR, 2'h0, 3'h0, 11'h020);
    pm(5, MXE_OP_ST_ACC_MEM, 2'h2, 3'h0, 11'h030);
    pm(6, MXE_OP_ROR, 2'h0, 3'h0, 11'h030);
    pm(7, MXE_OP_INVERT, 2'h0, 3'h0, 11'h030);
    rel();
    go(4);
    chk(acc, 8'h81);
    go(4);
    chk({acc[6:0], carry_flag}, 8'h05);
    go(12);
    chk(acc, 8'hc1);
    go(8);
    chk(acc, 8'he0);
    go(4);
    chk({acc[6:0], zero_flag}, 8'h7c);
    chk(mxe_mem_model_inst.dmem[8'h20], 8'hc2);
    chk(mxe_mem_model_inst.dmem[8'h30], 8'hc1);
  endtask

  task automatic s_skip;
    boot();
    mxe_mem_model_inst.dmem[8'h40] = 8'h02;
    pm(0, MXE_OP_SKBZ, 2'h0, 3'h1, 11'h040);
    pm(1, MXE_OP_LD_ACC_IMM, 2'h1, 3'h0, 11'h055);
    pm(2, MXE_OP_SKZ, 2'h0, 3'h0, 11'h041);
    pm(3, MXE_OP_LD_ACC_IMM, 2'h1, 3'h0, 11'h066);
    pm(4, MXE_OP_LD_ACC_IMM, 2'h1, 3'h0, 11'h077);
    rel();
    go(8);
    chk(acc, 8'h55);
    go(11);
    chk(acc, 8'h55);
    go(1);
    chk(acc, 8'h77);
  endtask

  task automatic s_pcl;
    boot();
    pm(0, MXE_OP_LD_ACC_IMM, 2'h1, 3'h0, 11'h003);
    pm(1, MXE_OP_ST_ACC_MEM, 2'h2, 3'h0, 11'h000);
    pm(2, MXE_OP_LD_ACC_IMM, 2'h1, 3'h0, 11'h0ee);
    pm(3, MXE_OP_LD_ACC_IMM, 2'h1, 3'h0, 11'h099);
    rel();
    go(15);
    chk(acc, 8'h03);
    go(1);
    chk(acc, 8'h99);
  endtask

  task automatic s_table;
    boot();
    mxe_mem_model_inst.pmem[7] = INSTR_W'(16'hbeef);
    pm(0, MXE_OP_LD_ACC_IMM, 2'h1, 3'h0, 11'h007);
    pm(1, MXE_OP_TABRD, 2'h2, 3'h0, 11'h050);
    pm(2, MXE_OP_LD_ACC_MEM, 2'h0, 3'h0, 11'h050);
    rel();
    go(15);
    chk(acc, 8'h07);
    go(1);
    chk(acc, 8'hef);
    chk(tbl_high, 8'hbe);
  endtask

  // limitation: pulse phase is not pinned, only the count per window
  task automatic s_halt;
    int nw;
    int nc;
    nw = 0;
    nc = 0;
    boot();
    pm(0, MXE_OP_WDTCLR, 2'h0, 3'h0, 11'h000);
    pm(1, MXE_OP_HALT, 2'h0, 3'h0, 11'h000);
    pm(2, MXE_OP_LD_ACC_IMM, 2'h1, 3'h0, 11'h05a);
    rel();
    for (int i = 0; i < 8; i++) begin
      go(1);
      nw += int'(wdt_clear === 1'b1);
      nc += int'(cycle_end === 1'b1);
    end
    chk(8'(nw), 8'h01);
    chk(8'(nc), 8'h02);
    go(20);
    chk({acc[6:0], power_down}, 8'h01);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rstn = 1'b0;
    s_jump();
    s_call(MXE_OP_RETURN, 8'h33, 1'b0);
    s_call(MXE_OP_INT_RETURN, 8'h44, 1'b1);
    s_alu();
    s_mem();
    s_skip();
    s_pcl();
    s_table();
    s_halt();
    finish_test();
  end
endmodule // mxe_core_tb
